// file: core/tpx_params.svh
// constants of the timer and port instruction executer
`ifndef TPX_PARAMS_SVH
`define TPX_PARAMS_SVH

// opcodes, ten bits
`define TPX_OP_TMR_RD 10'h270
`define TPX_OP_TMR_WR 10'h230
`define TPX_OP_RLD1 10'h23f
`define TPX_OP_RLD3 10'h23b
`define TPX_OP_FLAG_SKIP 10'h280
`define TPX_OP_PORT_IN 10'h260
`define TPX_OP_PORT_OUT 10'h220
`define TPX_OP_PD_ALL_OFF 10'h011
`define TPX_OP_PD_CLR 10'h014
`define TPX_OP_PD_SET 10'h015
`define TPX_OP_PD_SKIP1 10'h024
`define TPX_OP_PD_SKIP2 10'h02b
`define TPX_OP_WR_WAKE 10'h21b
`define TPX_OP_RD_WAKE 10'h256
`define TPX_OP_WR_PULL 10'h22d
`define TPX_OP_RD_PULL 10'h257
`define TPX_OP_WR_DIR 10'h228

// port numbers in the low opcode bits
`define TPX_PORT2 3'h2
`define TPX_PORT4 3'h4
`define TPX_PORT5 3'h5

// apb byte offsets
`define TPX_ADDR_CTRL 8'h00
`define TPX_ADDR_IRQ_STAT 8'h04
`define TPX_ADDR_IRQ_MASK 8'h08
`define TPX_ADDR_CTL_REGS 8'h0c
`define TPX_ADDR_PORTD 8'h10
`define TPX_ADDR_LAST_OP 8'h14

// field positions and reset values
`define TPX_CTRL_LARGE_BIT 0
`define TPX_EV_TMR_SKIP 0
`define TPX_EV_PD_SKIP 1
`define TPX_EV_ILLEGAL 2
`define TPX_RST_CTRL 1'h1
`define TPX_RST_PD 8'hff
`define TPX_RST_NIB 4'h0

`endif

// file: core/tpx_pkg.sv
// types of the timer and port instruction executer
package tpx_pkg;

  typedef enum logic [1:0] {
    TPX_ST_IDLE = 2'b01,
    TPX_ST_PD_WORD2 = 2'b10
  } tpx_state_e;

  typedef struct packed {
    logic valid;
    logic [9:0] opcode;
    logic [3:0] acc;
    logic [3:0] breg;
    logic [3:0] yreg;
  } tpx_req_s;

  typedef struct packed {
    logic done;
    logic acc_we;
    logic [3:0] acc;
    logic breg_we;
    logic [3:0] breg;
    logic skip;
  } tpx_res_s;

  typedef struct packed {
    logic [3:0] load_count;
    logic [3:0] load_reload;
    logic [7:0] data;
    logic [3:0] flag_clear;
  } tpx_tmr_cmd_s;

  typedef struct packed {
    logic [3:0] p0;
    logic [3:0] p1;
    logic [2:0] p2;
    logic [3:0] p3;
    logic [3:0] p4;
    logic [3:0] p5;
    logic [7:0] pd;
  } tpx_pins_s;

  typedef struct packed {
    logic [3:0] p0;
    logic [3:0] p1;
    logic [3:0] p3;
    logic [3:0] p4;
    logic [3:0] p5;
    logic [7:0] pd;
    logic [3:0] wakeup_control_reg;
    logic [3:0] pullup_control_reg;
    logic [3:0] direction_control_reg;
  } tpx_port_out_s;

endpackage : tpx_pkg

// file: core/tpx_pin_sync.sv
// three-stage pin synchroniser with agreement filter
module tpx_pin_sync #(
  parameter int WIDTH = 31
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_d;
  logic [WIDTH-1:0] out_q;

  // first stage feeds only the second
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= pin_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign pin_sync = out_q;

endmodule : tpx_pin_sync

// file: core/tpx_exec.sv
// timer and port instruction executer with apb status access
//
// Chosen here: the APB slave port and the placing of the registers.
`include "tpx_params.svh"

module tpx_exec (
  input wire logic pclk,
  input wire logic presetn,
  input wire tpx_pkg::tpx_req_s req,
  input wire logic [3:0][7:0] tmr_count,
  input wire logic [3:0] tmr_flag,
  input wire tpx_pkg::tpx_pins_s pins,
  output tpx_pkg::tpx_res_s res,
  output tpx_pkg::tpx_tmr_cmd_s tmr_cmd,
  output tpx_pkg::tpx_port_out_s port_out,
  output logic irq,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  function automatic logic [3:0] onehot4(input logic [1:0] idx);
    onehot4 = 4'h1 << idx;
  endfunction : onehot4

  function automatic logic same_grp(input logic [9:0] op, input logic [9:0] base);
    same_grp = (op[9:2] == base[9:2]);
  endfunction : same_grp

  tpx_pkg::tpx_pins_s pin_s;
  logic [30:0] pin_raw;

  tpx_pin_sync #(
    .WIDTH($bits(tpx_pkg::tpx_pins_s))
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_async(pins),
    .pin_sync(pin_raw)
  );
  assign pin_s = tpx_pkg::tpx_pins_s'(pin_raw);

  tpx_pkg::tpx_state_e state_q, state_d;
  tpx_pkg::tpx_res_s res_q, res_d;
  tpx_pkg::tpx_tmr_cmd_s tmr_q, tmr_d;
  tpx_pkg::tpx_port_out_s port_q, port_d;
  logic [3:0] y_q, y_d;
  logic [9:0] last_op_q, last_op_d;
  logic [2:0] ev;
  logic large_q, large_d;
  logic [2:0] stat_q, stat_d;
  logic [2:0] mask_q, mask_d;
  logic irq_q, irq_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;

  // instruction execution
  always_comb begin
    logic [9:0] op;
    logic [1:0] idx;
    logic [2:0] pn;
    logic [7:0] cnt;
    op = req.opcode;
    idx = op[1:0];
    pn = op[2:0];
    cnt = tmr_count[idx];
    state_d = state_q;
    res_d = '0;
    tmr_d = '0;
    port_d = port_q;
    y_d = y_q;
    last_op_d = last_op_q;
    ev = '0;
    if (req.valid) begin
      last_op_d = op;
      if (state_q == tpx_pkg::TPX_ST_PD_WORD2) begin
        state_d = tpx_pkg::TPX_ST_IDLE;
        if (op == `TPX_OP_PD_SKIP2) begin
          res_d.done = 1'b1;
          res_d.skip = ~pin_s.pd[y_q[2:0]];
          ev[`TPX_EV_PD_SKIP] = ~pin_s.pd[y_q[2:0]];
        end else begin
          // broken pair: second word dropped, no skip
          ev[`TPX_EV_ILLEGAL] = 1'b1;
        end
      end else if (same_grp(op, `TPX_OP_TMR_RD)) begin
        res_d.done = 1'b1;
        res_d.acc_we = 1'b1;
        res_d.breg_we = 1'b1;
        res_d.breg = cnt[7:4];
        res_d.acc = cnt[3:0];
      end else if (same_grp(op, `TPX_OP_TMR_WR)) begin
        res_d.done = 1'b1;
        tmr_d.load_count = onehot4(idx);
        tmr_d.load_reload = onehot4(idx);
        tmr_d.data = {req.breg, req.acc};
      end else if (op == `TPX_OP_RLD1 || op == `TPX_OP_RLD3) begin
        res_d.done = 1'b1;
        tmr_d.load_reload = (op == `TPX_OP_RLD1) ? 4'h1 : 4'h4;
        tmr_d.data = {req.breg, req.acc};
      end else if (same_grp(op, `TPX_OP_FLAG_SKIP)) begin
        res_d.done = 1'b1;
        res_d.skip = tmr_flag[idx];
        tmr_d.flag_clear = tmr_flag[idx] ? onehot4(idx) : 4'h0;
        ev[`TPX_EV_TMR_SKIP] = tmr_flag[idx];
      end else if (op[9:3] == `TPX_OP_PORT_IN >> 3 && pn <= `TPX_PORT5) begin
        if (pn[2] && !large_q) begin
          ev[`TPX_EV_ILLEGAL] = 1'b1;
        end else begin
          res_d.done = 1'b1;
          res_d.acc_we = 1'b1;
          unique case (pn)
            3'h0: res_d.acc = pin_s.p0;
            3'h1: res_d.acc = pin_s.p1;
            `TPX_PORT2: res_d.acc = {1'b0, pin_s.p2};
            3'h3: res_d.acc = pin_s.p3;
            `TPX_PORT4: res_d.acc = pin_s.p4;
            default: res_d.acc = pin_s.p5;
          endcase
        end
      end else if (op[9:3] == `TPX_OP_PORT_OUT >> 3 && pn <= `TPX_PORT5
                   && pn != `TPX_PORT2) begin
        if (pn[2] && !large_q) begin
          ev[`TPX_EV_ILLEGAL] = 1'b1;
        end else begin
          res_d.done = 1'b1;
          unique case (pn)
            3'h0: port_d.p0 = req.acc;
            3'h1: port_d.p1 = req.acc;
            3'h3: port_d.p3 = req.acc;
            `TPX_PORT4: port_d.p4 = req.acc;
            default: port_d.p5 = req.acc;
          endcase
        end
      end else if (op == `TPX_OP_PD_ALL_OFF) begin
        res_d.done = 1'b1;
        port_d.pd = 8'hff;
      end else if (op == `TPX_OP_PD_CLR || op == `TPX_OP_PD_SET) begin
        if (req.yreg[3]) begin
          // index past 7 leaves port D alone
          ev[`TPX_EV_ILLEGAL] = 1'b1;
        end else begin
          res_d.done = 1'b1;
          port_d.pd[req.yreg[2:0]] = op[0];
        end
      end else if (op == `TPX_OP_PD_SKIP1) begin
        if (req.yreg[3]) begin
          ev[`TPX_EV_ILLEGAL] = 1'b1;
        end else begin
          state_d = tpx_pkg::TPX_ST_PD_WORD2;
          y_d = req.yreg;
        end
      end else if (op == `TPX_OP_WR_WAKE) begin
        res_d.done = 1'b1;
        port_d.wakeup_control_reg = req.acc;
      end else if (op == `TPX_OP_WR_PULL) begin
        res_d.done = 1'b1;
        port_d.pullup_control_reg = req.acc;
      end else if (op == `TPX_OP_WR_DIR) begin
        if (!large_q) begin
          ev[`TPX_EV_ILLEGAL] = 1'b1;
        end else begin
          res_d.done = 1'b1;
          port_d.direction_control_reg = req.acc;
        end
      end else if (op == `TPX_OP_RD_WAKE || op == `TPX_OP_RD_PULL) begin
        res_d.done = 1'b1;
        res_d.acc_we = 1'b1;
        res_d.acc = op[0] ? port_q.pullup_control_reg
                          : port_q.wakeup_control_reg;
      end
    end
  end

  // apb slave and interrupt
  always_comb begin
    logic acc_ph;
    acc_ph = psel && penable && pready_q;
    large_d = large_q;
    mask_d = mask_q;
    // set wins over the write-one clear
    stat_d = stat_q | ev;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    pready_d = psel && !penable && !pready_q;
    if (psel && !penable) begin
      prdata_d = '0;
      unique case (paddr)
        `TPX_ADDR_CTRL: prdata_d[`TPX_CTRL_LARGE_BIT] = large_q;
        `TPX_ADDR_IRQ_STAT: prdata_d[2:0] = stat_q;
        `TPX_ADDR_IRQ_MASK: prdata_d[2:0] = mask_q;
        `TPX_ADDR_CTL_REGS: prdata_d[11:0] = {port_q.direction_control_reg,
                                              port_q.pullup_control_reg,
                                              port_q.wakeup_control_reg};
        `TPX_ADDR_PORTD: prdata_d[7:0] = port_q.pd;
        `TPX_ADDR_LAST_OP: prdata_d[9:0] = last_op_q;
        default: pslverr_d = 1'b1;
      endcase
    end
    if (acc_ph && pwrite) begin
      unique case (paddr)
        `TPX_ADDR_CTRL: large_d = pwdata[`TPX_CTRL_LARGE_BIT];
        `TPX_ADDR_IRQ_STAT: stat_d = (stat_q & ~pwdata[2:0]) | ev;
        `TPX_ADDR_IRQ_MASK: mask_d = pwdata[2:0];
        default: ;
      endcase
    end
    if (acc_ph) begin
      pslverr_d = 1'b0;
    end
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= tpx_pkg::TPX_ST_IDLE;
      res_q <= '0;
      tmr_q <= '0;
      port_q <= '{p0: `TPX_RST_NIB, p1: `TPX_RST_NIB, p3: `TPX_RST_NIB,
                  p4: `TPX_RST_NIB, p5: `TPX_RST_NIB, pd: `TPX_RST_PD,
                  wakeup_control_reg: `TPX_RST_NIB,
                  pullup_control_reg: `TPX_RST_NIB,
                  direction_control_reg: `TPX_RST_NIB};
      y_q <= '0;
      last_op_q <= '0;
      large_q <= `TPX_RST_CTRL;
      stat_q <= '0;
      mask_q <= '0;
      irq_q <= 1'b0;
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      state_q <= state_d;
      res_q <= res_d;
      tmr_q <= tmr_d;
      port_q <= port_d;
      y_q <= y_d;
      last_op_q <= last_op_d;
      large_q <= large_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign res = res_q;
  assign tmr_cmd = tmr_q;
  assign port_out = port_q;
  assign irq = irq_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic rd_hit;
  assign rd_hit = req.valid && state_q == tpx_pkg::TPX_ST_IDLE;

  AST_TMR_READ: assert property (
    rd_hit && same_grp(req.opcode, `TPX_OP_TMR_RD) |=>
      res.acc_we && res.breg_we
      && {res.breg, res.acc} == $past(tmr_count[req.opcode[1:0]]))
    else $error("timer read result wrong");

  AST_TMR_WRITE: assert property (
    rd_hit && same_grp(req.opcode, `TPX_OP_TMR_WR) |=>
      tmr_cmd.load_count == tmr_cmd.load_reload && $onehot(tmr_cmd.load_count)
      && tmr_cmd.data == {$past(req.breg), $past(req.acc)})
    else $error("timer write strobes wrong");

  AST_RLD_ONLY: assert property (
    rd_hit && req.opcode == `TPX_OP_RLD3 |=>
      tmr_cmd.load_count == 4'h0 && tmr_cmd.load_reload == 4'h4)
    else $error("reload-only write touched count");

  AST_FLAG_SKIP: assert property (
    rd_hit && same_grp(req.opcode, `TPX_OP_FLAG_SKIP) |=>
      res.skip == $past(tmr_flag[req.opcode[1:0]]) && (|tmr_cmd.flag_clear) == res.skip)
    else $error("flag skip or clear wrong");

  AST_PORT2_READ: assert property (
    rd_hit && req.opcode == (`TPX_OP_PORT_IN | 10'h002) |=>
      res.acc_we && !res.acc[3] && res.acc[2:0] == $past(pin_s.p2))
    else $error("port 2 read wrong");

  AST_PD_CLEAR: assert property (
    rd_hit && req.opcode == `TPX_OP_PD_CLR && !req.yreg[3] |=>
      !port_out.pd[$past(req.yreg[2:0])])
    else $error("port D bit not cleared");

  AST_PD_SET: assert property (
    rd_hit && req.opcode == `TPX_OP_PD_SET && !req.yreg[3] |=>
      port_out.pd[$past(req.yreg[2:0])])
    else $error("port D bit not set");

  AST_PD_TEST: assert property (
    rd_hit && req.opcode == `TPX_OP_PD_SKIP1 && !req.yreg[3] ##1
      req.valid && req.opcode == `TPX_OP_PD_SKIP2 |=> res.done
      && res.skip == !$past(pin_s.pd[y_q[2:0]]))
    else $error("port D bit test wrong");

  AST_SMALL_VARIANT: assert property (
    rd_hit && !large_q && req.opcode == `TPX_OP_WR_DIR |=>
      $stable(port_out.direction_control_reg) && !res.done)
    else $error("small variant executed direction write");

  AST_ALL_OFF: assert property (
    rd_hit && req.opcode == `TPX_OP_PD_ALL_OFF |=> port_out.pd == 8'hff && res.done)
    else $error("port D all-off failed");

endmodule : tpx_exec

// file: test/tpx_tmr_model.sv
// timer unit model: holds counts, reloads and underflow flags
module tpx_tmr_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire tpx_pkg::tpx_tmr_cmd_s cmd,
  input wire logic [3:0] set_flag,
  output logic [3:0][7:0] count,
  output logic [3:0][7:0] reload,
  output logic [3:0] flag
);
  timeunit 1ns;
  timeprecision 1ps;
  // counts stand still: counting is outside this block, so reads stay predictable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        count[i] <= 8'h5a + 8'(i * 17);
        reload[i] <= 8'h00;
      end
      flag <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (cmd.load_count[i]) count[i] <= cmd.data;
        if (cmd.load_reload[i]) reload[i] <= cmd.data;
      end
      flag <= (flag & ~cmd.flag_clear) | set_flag;
    end
  end
endmodule : tpx_tmr_model

// file: test/testbench.sv
// self-checking bench of the timer and port instruction executer
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  tpx_pkg::tpx_req_s req = '0;
  tpx_pkg::tpx_pins_s pins = {4'h6, 4'h9, 3'h7, 4'ha, 4'h3, 4'hc, 8'h55};
  tpx_pkg::tpx_res_s res;
  tpx_pkg::tpx_tmr_cmd_s tmr_cmd;
  tpx_pkg::tpx_port_out_s port_out;
  logic [3:0][7:0] count;
  logic [3:0][7:0] reload;
  logic [3:0] flag;
  logic [3:0] set_flag = 4'h0;
  logic irq;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rd;
  logic err;
  int failures = 0;
  int samples_checked = 0;
  int cyc = 0;

  always #5 pclk = ~pclk;

  tpx_exec dut_u (.pclk(pclk), .presetn(presetn), .req(req), .tmr_count(count),
    .tmr_flag(flag), .pins(pins), .res(res), .tmr_cmd(tmr_cmd), .port_out(port_out),
    .irq(irq), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  tpx_tmr_model tmr_u (.pclk(pclk), .presetn(presetn), .cmd(tmr_cmd),
    .set_flag(set_flag), .count(count), .reload(reload), .flag(flag));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task end_of_test();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      end_of_test();
    end
  end

  // one word; result sampled 1 ns after the taking edge, while it stands
  task automatic exe(input logic [9:0] op, input logic [3:0] b, input logic [3:0] a,
      input logic [3:0] y);
    @(posedge pclk);
    req <= '{valid: 1'h1, opcode: op, acc: a, breg: b, yreg: y};
    @(posedge pclk);
    req.valid <= 1'h0;
    #1;
  endtask : exe

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // only the bench timeout ends a hung wait; the slave answers in the first access cycle
    chk("apb_wait", 32'h1, 32'(n));
  endtask : apb

  task automatic t_apb_map();
    apb(1'h0, 8'h00, 32'h0);
    chk("ctrl_rst", 32'h1, rd);
    apb(1'h0, 8'h08, 32'h0);
    chk("mask_rst", 32'h0, rd);
    apb(1'h0, 8'h10, 32'h0);
    chk("pd_rst", 32'hff, rd);
    apb(1'h1, 8'h20, 32'h5);
    apb(1'h0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], err});
  endtask : t_apb_map

  task automatic t_timer_rd();
    logic [7:0] e;
    for (int i = 0; i < 4; i++) begin
      e = 8'h5a + 8'(i * 17);
      exe(10'h270 + 10'(i), 4'h0, 4'h0, 4'h0);
      chk("rd_val", 32'(e), {24'h0, res.breg, res.acc});
      chk("rd_we", 32'h7, {29'h0, res.done, res.acc_we, res.breg_we});
      chk("rd_keep", 32'(e), {16'h0, tmr_cmd.load_count, tmr_cmd.load_reload, count[i]});
    end
  endtask : t_timer_rd

  task automatic t_timer_wr();
    exe(10'h232, 4'hb, 4'h4, 4'h0);
    exe(10'h23f, 4'h2, 4'he, 4'h0);
    chk("wr_both", 32'hb4b4, {16'h0, count[2], reload[2]});
    exe(10'h23b, 4'h6, 4'h1, 4'h0);
    @(posedge pclk);
    #1;
    chk("rld1", 32'h5a2e, {16'h0, count[0], reload[0]});
    chk("rld3", 32'hb461, {16'h0, count[2], reload[2]});
  endtask : t_timer_wr

  task automatic t_flag();
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      set_flag <= 4'(4'h1 << i);
      @(posedge pclk);
      set_flag <= 4'h0;
      exe(10'h280 + 10'(i), 4'h0, 4'h0, 4'h0);
      chk("flg_skip", {28'h1, 4'(4'h1 << i)}, {27'h0, res.skip, tmr_cmd.flag_clear});
      exe(10'h280 + 10'(i), 4'h0, 4'h0, 4'h0);
      chk("flg_none", 32'h2, {30'h0, res.done, res.skip | flag[i]});
    end
  endtask : t_flag

  task automatic t_port_io();
    logic [3:0] pv [6] = '{4'h6, 4'h9, 4'h7, 4'ha, 4'h3, 4'hc};
    for (int n = 0; n < 6; n++) begin
      exe(10'h260 + 10'(n), 4'h0, 4'hf, 4'h0);
      chk("port_in", 32'(pv[n]), 32'(res.acc));
    end
    @(posedge pclk);
    pins.p0 <= 4'h3;
    // pin change needs the synchroniser's latency before a read sees it
    repeat (5) @(posedge pclk);
    exe(10'h260, 4'h0, 4'h0, 4'h0);
    chk("port_in_new", 32'h3, 32'(res.acc));
    exe(10'h220, 4'h0, 4'h1, 4'h0);
    exe(10'h221, 4'h0, 4'h2, 4'h0);
    exe(10'h223, 4'h0, 4'h4, 4'h0);
    exe(10'h224, 4'h0, 4'h8, 4'h0);
    exe(10'h225, 4'h0, 4'hf, 4'h0);
    chk("port_out", 32'h1248f, {12'h0, port_out.p0, port_out.p1, port_out.p3,
      port_out.p4, port_out.p5});
    exe(10'h222, 4'h0, 4'h5, 4'h0);
    chk("p2_out", 32'h0, 32'(res.done));
  endtask : t_port_io

  task automatic t_portd();
    exe(10'h014, 4'h0, 4'h0, 4'h0);
    chk("pd_clr0", 32'hfe, 32'(port_out.pd));
    exe(10'h011, 4'h0, 4'h0, 4'h0);
    chk("pd_off", 32'hff, 32'(port_out.pd));
    exe(10'h014, 4'h0, 4'h0, 4'h7);
    exe(10'h014, 4'h0, 4'h0, 4'h3);
    chk("pd_clr", 32'h77, 32'(port_out.pd));
    exe(10'h015, 4'h0, 4'h0, 4'h3);
    chk("pd_set", 32'h7f, 32'(port_out.pd));
    exe(10'h014, 4'h0, 4'h0, 4'h8);
    chk("pd_y8", 32'h7f, {23'h0, res.done, port_out.pd});
    // both words back to back, y = 3 reads pin 0: skip
    @(posedge pclk);
    req <= '{valid: 1'h1, opcode: 10'h024, acc: 4'h0, breg: 4'h0, yreg: 4'h3};
    @(posedge pclk);
    req.opcode <= 10'h02b;
    #1;
    chk("szd_w1", 32'h0, 32'(res.done));
    @(posedge pclk);
    req.valid <= 1'h0;
    #1;
    chk("szd_w2", 32'h3, {30'h0, res.done, res.skip});
    // words with an idle cycle between, y = 0 reads pin 1: no skip
    exe(10'h024, 4'h0, 4'h0, 4'h0);
    chk("szd_w1", 32'h0, 32'(res.done));
    exe(10'h02b, 4'h0, 4'h0, 4'h0);
    chk("szd_w2", 32'h2, {30'h0, res.done, res.skip});
  endtask : t_portd

  task automatic t_ctrl_regs();
    exe(10'h21b, 4'h0, 4'h5, 4'h0);
    exe(10'h22d, 4'h0, 4'ha, 4'h0);
    exe(10'h228, 4'h0, 4'h3, 4'h0);
    chk("ctl_wr", 32'h5a3, {20'h0, port_out.wakeup_control_reg,
      port_out.pullup_control_reg, port_out.direction_control_reg});
    exe(10'h256, 4'h0, 4'h0, 4'h0);
    chk("wake_rd", 32'h5, 32'(res.acc));
    exe(10'h257, 4'h0, 4'h0, 4'h0);
    chk("pull_rd", 32'ha, 32'(res.acc));
    apb(1'h0, 8'h0c, 32'h0);
    chk("ctl_apb", 32'h3a5, rd);
  endtask : t_ctrl_regs

  task automatic t_variant_irq();
    apb(1'h1, 8'h00, 32'h0);
    exe(10'h264, 4'h0, 4'h0, 4'h0);
    chk("small_p4", 32'h0, 32'(res.done));
    exe(10'h228, 4'h0, 4'hc, 4'h0);
    chk("small_dir", 32'h3, {27'h0, res.done, port_out.direction_control_reg});
    apb(1'h0, 8'h04, 32'h0);
    chk("irq_off", 32'h7, {28'h0, irq, rd[2:0]});
    apb(1'h1, 8'h08, 32'h4);
    apb(1'h0, 8'h08, 32'h0);
    chk("irq_on", 32'h1, 32'(irq));
    apb(1'h1, 8'h04, 32'h4);
    apb(1'h0, 8'h04, 32'h0);
    chk("irq_clr", 32'h3, {28'h0, irq, rd[2:0]});
    apb(1'h1, 8'h00, 32'h1);
    exe(10'h264, 4'h0, 4'h0, 4'h0);
    chk("large_p4", 32'h13, {27'h0, res.done, res.acc});
  endtask : t_variant_irq

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    t_apb_map();
    t_timer_rd();
    t_timer_wr();
    t_flag();
    t_port_io();
    t_portd();
    t_ctrl_regs();
    t_variant_irq();
    end_of_test();
  end
endmodule : testbench
